//--- core/srtc_core.sv
// Sweep ramp trigger control: host latches, ramp switching and trigger sequencing
`default_nettype none
module srtc_core #(
	parameter logic [1:0] MODE_INT = srtc_pkg::MODE_INT_DEF,
	parameter logic [1:0] MODE_LINE = srtc_pkg::MODE_LINE_DEF,
	parameter logic [1:0] MODE_EXT = srtc_pkg::MODE_EXT_DEF,
	parameter logic [1:0] MODE_SGL = srtc_pkg::MODE_SGL_DEF,
	parameter int PULSE_CYCLES = srtc_pkg::TRIG_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hostWrEn,
	input wire logic [15:0] hostAddr,
	input wire logic [7:0] hostWrData,
	input wire logic highLimitN,
	input wire logic lowLimit,
	input wire logic lineTrigN,
	input wire logic extTrigN,
	output logic [srtc_pkg::RATE_W-1:0] rateCode,
	output logic refBoostOn,
	output logic capLargeSel,
	output logic capSmallSel,
	output logic rampOutSel,
	output logic manualFeedbackSel,
	output logic manualOutSel,
	output logic retraceEnable,
	output logic stopHold,
	output logic sweepPhaseFlag,
	output logic clampRefRaise,
	output logic sweepOutInternal,
	output logic sweepOutPanel,
	output logic [1:0] trigMode
);
	import srtc_pkg::*;

	// ------------------------------------------------------------
	// Host control latches
	// ------------------------------------------------------------
	logic [7:0] ctrl0_ff;
	logic [7:0] ctrl1_ff;
	logic [7:0] ctrl2_ff;
	logic [7:0] rateHi_ff;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
		hit = hostWrEn && (a == target);
	endfunction

	// Addresses outside the four are dropped silently
	// Write-only; nothing here is readable
	// address decode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_ff <= RST_CTRL0;
		end else if (hit(hostAddr, ADDR_CTRL0)) begin
			ctrl0_ff <= hostWrData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_ff <= RST_CTRL1;
		end else if (hit(hostAddr, ADDR_CTRL1)) begin
			ctrl1_ff <= hostWrData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl2_ff <= RST_CTRL2;
		end else if (hit(hostAddr, ADDR_CTRL2)) begin
			ctrl2_ff <= hostWrData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rateHi_ff <= RST_RATE_HI;
		end else if (hit(hostAddr, ADDR_RATE_HI)) begin
			rateHi_ff <= hostWrData;
		end
	end

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	logic abortN;
	logic clampDisableN;
	logic externalSweepN;
	logic externalSweepSelN;
	logic trigSelBit0;
	logic trigSelBit1;
	logic stopSweepReqN;
	logic stopForwardReqN;
	logic singleTrigN;
	logic remoteTrigN;
	logic manual;
	logic rangeLong;
	logic rangeShort;

	assign abortN = ctrl0_ff[C0_ABORT_N];
	assign clampDisableN = ctrl0_ff[C0_CLAMP_DIS_N];
	assign externalSweepN = ctrl0_ff[C0_EXT_SWEEP_N];
	assign externalSweepSelN = ctrl0_ff[C0_EXT_SWEEP_SEL_N];
	assign trigSelBit0 = ctrl0_ff[C0_TRIG_SEL0];
	assign trigSelBit1 = ctrl0_ff[C0_TRIG_SEL1];
	assign stopSweepReqN = ctrl1_ff[C1_STOP_SWEEP_N];
	assign stopForwardReqN = ctrl1_ff[C1_STOP_FWD_N];
	assign singleTrigN = ctrl1_ff[C1_SINGLE_TRIG_N];
	assign remoteTrigN = ctrl1_ff[C1_REMOTE_TRIG_N];
	assign manual = ctrl2_ff[C2_MANUAL];
	assign rangeLong = ctrl2_ff[C2_RANGE_LONG];
	assign rangeShort = ctrl2_ff[C2_RANGE_SHORT];

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [3:0] syncA_ff;
	logic [3:0] syncB_ff;
	logic highLimitActive;
	logic lowLimitActive;
	logic lineTrigSyncN;
	logic extTrigSyncN;

	// Two cycles of lag; with the latch and retrace registers the ramp overshoots each limit by four cycles
	// two-stage synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_ff <= 4'hD;
			syncB_ff <= 4'hD;
		end else begin
			syncA_ff <= {extTrigN, lineTrigN, lowLimit, highLimitN};
			syncB_ff <= syncA_ff;
		end
	end

	// Comparator at high limit drives low
	assign highLimitActive = ~syncB_ff[0];
	assign lowLimitActive = syncB_ff[1];
	assign lineTrigSyncN = syncB_ff[2];
	assign extTrigSyncN = syncB_ff[3];

	// ------------------------------------------------------------
	// Trigger source selection
	// ------------------------------------------------------------
	logic [1:0] modeSel;
	logic isInternal;
	logic timerTrigN;
	logic trigPulse;

	assign modeSel = {trigSelBit1, trigSelBit0};
	assign isInternal = (modeSel == MODE_INT);

	// Latch bits are already clocked here, so they skip the synchronisers
	// Single and remote share one mode code; either key fires it
	always_comb begin
		timerTrigN = 1'b1;
		case (modeSel)
			MODE_INT: timerTrigN = 1'b1;
			MODE_LINE: timerTrigN = lineTrigSyncN;
			MODE_EXT: timerTrigN = extTrigSyncN;
			MODE_SGL: timerTrigN = singleTrigN & remoteTrigN;
			default: timerTrigN = 1'b1;
		endcase
	end

	// Edge, not level: a line held low fires one pulse only
	// 40 us pulse on low trigger
	srtc_pulse_timer #(
		.PULSE_CYCLES(PULSE_CYCLES)
	) uTimer (
		.clk(clk),
		.rst_n(rst_n),
		.trigIn_n(timerTrigN),
		.pulse(trigPulse)
	);

	// ------------------------------------------------------------
	// Trigger latches
	// ------------------------------------------------------------
	logic internalTriggerLatch_ff;
	logic externalTriggerLatch_ff;
	logic nxt_internalTriggerLatch;
	logic nxt_externalTriggerLatch;
	logic extSet;
	logic extReset;

	// Set has priority, as a stuck high limit must force retrace
	always_comb begin
		nxt_internalTriggerLatch = internalTriggerLatch_ff;
		if (lowLimitActive) begin
			nxt_internalTriggerLatch = 1'b0;
		end
		if (highLimitActive) begin
			nxt_internalTriggerLatch = 1'b1;
		end
	end

	assign extSet = highLimitActive | ~abortN;
	assign extReset = trigPulse & lowLimitActive;

	always_comb begin
		nxt_externalTriggerLatch = externalTriggerLatch_ff;
		if (extReset) begin
			nxt_externalTriggerLatch = 1'b0;
		end
		if (extSet) begin
			nxt_externalTriggerLatch = 1'b1;
		end
	end

	// Registers stand in for the set/reset latches of the analog side
	// flag follows ramp limits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			internalTriggerLatch_ff <= 1'b0;
			externalTriggerLatch_ff <= 1'b0;
		end else begin
			internalTriggerLatch_ff <= nxt_internalTriggerLatch;
			externalTriggerLatch_ff <= nxt_externalTriggerLatch;
		end
	end

	// ------------------------------------------------------------
	// Phase flag and retrace
	// ------------------------------------------------------------
	logic phaseNow;
	logic stopActive;
	logic nxt_retrace;

	assign phaseNow = isInternal ? internalTriggerLatch_ff : externalTriggerLatch_ff;

	// Stop sweep also cuts retrace; stop forward leaves it running
	// either stop request holds
	assign stopActive = ~manual & (~stopSweepReqN | ~stopForwardReqN);

	assign nxt_retrace = (~externalSweepN | phaseNow) & ~(~stopSweepReqN & ~manual);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sweepPhaseFlag <= 1'b0;
			retraceEnable <= 1'b0;
			stopHold <= 1'b0;
		end else begin
			sweepPhaseFlag <= phaseNow;
			retraceEnable <= nxt_retrace;
			stopHold <= stopActive;
		end
	end

	// ------------------------------------------------------------
	// Rate code and range switching
	// ------------------------------------------------------------
	// Halves land separately, so a two-write update shows a mixed code
	// 10-bit rate code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rateCode <= '0;
		end else begin
			rateCode <= {rateHi_ff, ctrl2_ff[C2_RATE_LO +: 2]};
		end
	end

	// Manual wins over both ranges so a capacitor never fights the resistors
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refBoostOn <= 1'b0;
			capLargeSel <= 1'b0;
			capSmallSel <= 1'b0;
			rampOutSel <= 1'b0;
			manualFeedbackSel <= 1'b0;
			manualOutSel <= 1'b0;
		end else begin
			refBoostOn <= ~manual & rangeLong;
			capLargeSel <= ~manual & rangeLong;
			capSmallSel <= ~manual & rangeShort & ~rangeLong;
			rampOutSel <= ~manual & (rangeShort | rangeLong);
			manualFeedbackSel <= manual;
			manualOutSel <= manual;
		end
	end

	// ------------------------------------------------------------
	// Clamp and output routing
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clampRefRaise <= 1'b0;
			sweepOutInternal <= 1'b1;
			sweepOutPanel <= 1'b0;
			trigMode <= MODE_INT_DEF;
		end else begin
			clampRefRaise <= ~clampDisableN;
			sweepOutInternal <= externalSweepSelN;
			sweepOutPanel <= ~externalSweepSelN;
			trigMode <= modeSel;
		end
	end
endmodule
`default_nettype wire

//--- core/srtc_pkg.sv
// Shared constants for the sweep ramp trigger control block
`default_nettype none
package srtc_pkg;
	// ------------------------------------------------------------
	// Host write addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_CTRL0 = 16'h2014;
	localparam logic [15:0] ADDR_CTRL1 = 16'h2015;
	localparam logic [15:0] ADDR_CTRL2 = 16'h2016;
	localparam logic [15:0] ADDR_RATE_HI = 16'h2017;

	// ------------------------------------------------------------
	// Latch 0 field positions
	// ------------------------------------------------------------
	localparam int C0_ABORT_N = 0;
	localparam int C0_CLAMP_DIS_N = 1;
	localparam int C0_EXT_SWEEP_N = 2;
	localparam int C0_TRIG_SEL0 = 3;
	localparam int C0_TRIG_SEL1 = 4;
	localparam int C0_EXT_SWEEP_SEL_N = 7;

	// ------------------------------------------------------------
	// Latch 1 field positions
	// ------------------------------------------------------------
	localparam int C1_STOP_SWEEP_N = 0;
	localparam int C1_STOP_FWD_N = 1;
	localparam int C1_SINGLE_TRIG_N = 2;
	localparam int C1_REMOTE_TRIG_N = 3;

	// ------------------------------------------------------------
	// Latch 2 field positions
	// ------------------------------------------------------------
	localparam int C2_RATE_LO = 0;
	localparam int C2_MANUAL = 2;
	localparam int C2_RANGE_LONG = 3;
	localparam int C2_RANGE_SHORT = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_CTRL0 = 8'h87;
	localparam logic [7:0] RST_CTRL1 = 8'h0F;
	localparam logic [7:0] RST_CTRL2 = 8'h10;
	localparam logic [7:0] RST_RATE_HI = 8'h00;

	// ------------------------------------------------------------
	// Trigger mode codes (defaults)
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_INT_DEF = 2'h0;
	localparam logic [1:0] MODE_LINE_DEF = 2'h1;
	localparam logic [1:0] MODE_EXT_DEF = 2'h2;
	localparam logic [1:0] MODE_SGL_DEF = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int TRIG_PULSE_US = 40;
	localparam int TRIG_PULSE_CYCLES = TRIG_PULSE_US * CLK_MHZ;
	localparam int RATE_W = 10;

	typedef enum logic {
		TMR_IDLE = 1'b0,
		TMR_PULSE = 1'b1
	} srtc_tmr_t;
endpackage
`default_nettype wire

//--- core/srtc_pulse_timer.sv
// One-shot trigger pulse timer for the sweep trigger path
`default_nettype none
module srtc_pulse_timer #(
	parameter int PULSE_CYCLES = srtc_pkg::TRIG_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trigIn_n,
	output logic pulse
);
	import srtc_pkg::*;

	srtc_tmr_t state_ff;
	logic [15:0] count_ff;
	logic trigPrev_ff;
	logic fall;

	assign fall = trigPrev_ff & ~trigIn_n;
	assign pulse = (state_ff == TMR_PULSE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trigPrev_ff <= 1'b1;
		end else begin
			trigPrev_ff <= trigIn_n;
		end
	end

	// ------------------------------------------------------------
	// Pulse sequencing
	// ------------------------------------------------------------
	// Not retriggerable: a new edge inside the pulse is ignored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= TMR_IDLE;
			count_ff <= 16'h0000;
		end else begin
			case (state_ff)
				TMR_IDLE: begin
					if (fall) begin
						state_ff <= TMR_PULSE;
						count_ff <= 16'(PULSE_CYCLES - 1);
					end
				end
				TMR_PULSE: begin
					if (count_ff == 16'h0000) begin
						state_ff <= TMR_IDLE;
					end else begin
						count_ff <= count_ff - 16'h0001;
					end
				end
				default: begin
					state_ff <= TMR_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- test/srtc_core_properties.sv
// Port assertions for the sweep ramp trigger control block
`default_nettype none
module srtc_core_checker #(
	parameter logic [1:0] MODE_INT = srtc_pkg::MODE_INT_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hostWrEn,
	input wire logic [15:0] hostAddr,
	input wire logic [7:0] hostWrData,
	input wire logic highLimitN,
	input wire logic lowLimit,
	input wire logic [srtc_pkg::RATE_W-1:0] rateCode,
	input wire logic refBoostOn,
	input wire logic capLargeSel,
	input wire logic capSmallSel,
	input wire logic manualFeedbackSel,
	input wire logic retraceEnable,
	input wire logic stopHold,
	input wire logic sweepPhaseFlag,
	input wire logic clampRefRaise,
	input wire logic sweepOutPanel,
	input wire logic [1:0] trigMode
);
	timeunit 1ns;
	timeprecision 1ps;
	import srtc_pkg::*;
	logic [7:0] wrData1_ff;
	logic [7:0] wrData2_ff;
	logic wrCtrl0;
	// Data delayed to meet the two-edge output latency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrData1_ff <= 8'h00;
			wrData2_ff <= 8'h00;
		end else begin
			wrData1_ff <= hostWrData;
			wrData2_ff <= wrData1_ff;
		end
	end
	assign wrCtrl0 = hostWrEn && hostAddr == ADDR_CTRL0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_rate_high:
	assert property (hostWrEn && hostAddr == ADDR_RATE_HI |-> ##2 rateCode[9:2] == wrData2_ff)
		else $error("rate high byte wrong");
	a_trig_mode:
	assert property (wrCtrl0 |-> ##2 trigMode == wrData2_ff[4:3])
		else $error("trigger mode wrong");
	a_clamp_raise:
	assert property (wrCtrl0 |-> ##2 clampRefRaise == !wrData2_ff[C0_CLAMP_DIS_N])
		else $error("clamp raise wrong");
	a_out_route:
	assert property (wrCtrl0 |-> ##2 sweepOutPanel == !wrData2_ff[C0_EXT_SWEEP_SEL_N])
		else $error("sweep routing wrong");
	a_long_range:
	assert property (capLargeSel |-> refBoostOn && !capSmallSel)
		else $error("long range switches wrong");
	a_stop_ignored:
	assert property (manualFeedbackSel |-> !stopHold && !capLargeSel && !capSmallSel)
		else $error("manual mode switching wrong");
	a_retrace_phase:
	assert property (sweepPhaseFlag && !stopHold && !manualFeedbackSel |-> retraceEnable)
		else $error("retrace off in retrace phase");
	a_limit_sets:
	assert property (!highLimitN [*5] |-> sweepPhaseFlag)
		else $error("high limit did not raise flag");
	a_int_low:
	assert property ((trigMode == MODE_INT && lowLimit && highLimitN) [*5] |-> !sweepPhaseFlag)
		else $error("low limit did not clear flag");
	a_ext_gate:
	assert property ((trigMode != MODE_INT && !lowLimit && sweepPhaseFlag && !hostWrEn) [*6]
		|=> sweepPhaseFlag) else $error("flag cleared away from low limit");
	a_abort_sets:
	assert property (wrCtrl0 && !hostWrData[0] && hostWrData[4:3] != MODE_INT
		&& trigMode != MODE_INT |-> ##[2:5] sweepPhaseFlag) else $error("abort did not retrace");
endmodule
`default_nettype wire

//--- test/srtc_ramp_model.sv
// Behavioural ramp integrator with its two limit comparators
`default_nettype none
module srtc_ramp_model #(
	parameter int HI_LEVEL = 100
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic retraceEnable,
	input wire logic stopHold,
	input wire logic manualFeedbackSel,
	output logic highLimitN,
	output logic lowLimit
);
	timeunit 1ns;
	timeprecision 1ps;
	int level;
	// Manual holds a static level; retrace floors at the bottom clamp
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 0;
		end else if (!manualFeedbackSel) begin
			if (retraceEnable) begin
				level <= (level > 2) ? level - 2 : 0;
			end else if (!stopHold) begin
				level <= level + 1;
			end
		end
	end
	assign highLimitN = !(level >= HI_LEVEL);
	assign lowLimit = (level <= 0);
endmodule
`default_nettype wire

//--- test/srtc_core_bench.sv
// Self-checking bench for the sweep ramp trigger control block
`default_nettype none
module srtc_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import srtc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hostWrEn = 1'b0;
	logic [15:0] hostAddr = 16'h0000;
	logic [7:0] hostWrData = 8'h00;
	logic lineTrigN = 1'b1;
	logic extTrigN = 1'b1;
	logic highLimitN, lowLimit, refBoostOn, capLargeSel, capSmallSel, rampOutSel;
	logic manualFeedbackSel, manualOutSel, retraceEnable, stopHold, sweepPhaseFlag;
	logic clampRefRaise, sweepOutInternal, sweepOutPanel;
	logic [RATE_W-1:0] rateCode;
	logic [1:0] trigMode;
	logic [7:0] shadow [4];
	logic [1:0] trigCodes [4] = '{MODE_LINE_DEF, MODE_EXT_DEF, MODE_SGL_DEF, MODE_SGL_DEF};
	logic [23:0] expQ [$];
	int nMismatch = 0;
	int samplesChecked = 0;
	event sampleEv;
	wire logic [23:0] obsVec = {rateCode, refBoostOn, capLargeSel, capSmallSel, rampOutSel,
		manualFeedbackSel, manualOutSel, retraceEnable, stopHold, sweepPhaseFlag,
		clampRefRaise, sweepOutInternal, sweepOutPanel, trigMode};

	srtc_core #(.PULSE_CYCLES(20)) srtc_core_i (.clk(clk), .rst_n(rst_n), .hostWrEn(hostWrEn),
		.hostAddr(hostAddr), .hostWrData(hostWrData), .highLimitN(highLimitN),
		.lowLimit(lowLimit), .lineTrigN(lineTrigN), .extTrigN(extTrigN), .rateCode(rateCode),
		.refBoostOn(refBoostOn), .capLargeSel(capLargeSel), .capSmallSel(capSmallSel),
		.rampOutSel(rampOutSel), .manualFeedbackSel(manualFeedbackSel),
		.manualOutSel(manualOutSel), .retraceEnable(retraceEnable), .stopHold(stopHold),
		.sweepPhaseFlag(sweepPhaseFlag), .clampRefRaise(clampRefRaise),
		.sweepOutInternal(sweepOutInternal), .sweepOutPanel(sweepOutPanel), .trigMode(trigMode));
	srtc_ramp_model srtc_ramp_model_i (.clk(clk), .rst_n(rst_n), .retraceEnable(retraceEnable),
		.stopHold(stopHold), .manualFeedbackSel(manualFeedbackSel), .highLimitN(highLimitN),
		.lowLimit(lowLimit));

	initial begin
		forever #4 clk = ~clk;
	end

	// ----
	// Expected outputs from the shadow latches
	// ----
	function automatic logic [23:0] expVec(input logic flag);
		logic man;
		logic lng;
		logic sht;
		logic stopSw;
		man = shadow[2][C2_MANUAL];
		lng = shadow[2][C2_RANGE_LONG];
		sht = shadow[2][C2_RANGE_SHORT];
		stopSw = !shadow[1][C1_STOP_SWEEP_N] && !man;
		return {shadow[3], shadow[2][1:0], lng && !man, lng && !man, sht && !lng && !man,
			(sht || lng) && !man, man, man, (!shadow[0][C0_EXT_SWEEP_N] || flag) && !stopSw,
			stopSw || (!shadow[1][C1_STOP_FWD_N] && !man), flag, !shadow[0][C0_CLAMP_DIS_N],
			shadow[0][C0_EXT_SWEEP_SEL_N], !shadow[0][C0_EXT_SWEEP_SEL_N], shadow[0][4:3]};
	endfunction

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		hostWrEn <= 1'b1;
		hostAddr <= a;
		hostWrData <= d;
		if (a >= ADDR_CTRL0 && a <= ADDR_RATE_HI) begin
			shadow[a[1:0]] = d;
		end
	endtask

	task automatic wrEnd;
		@(posedge clk);
		hostWrEn <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic expectNow(input logic flag);
		expQ.push_back(expVec(flag));
		->sampleEv;
	endtask

	task automatic compareVec(input logic [23:0] e, input logic [23:0] o);
		samplesChecked++;
		if (o !== e) begin
			nMismatch++;
			$display("mismatch at %0t: expected %h observed %h", $time, e, o);
		end
	endtask

	// Selector: 0 phase flag, 1 low limit, 2 high limit
	task automatic waitSig(input int w, input logic v, input int limit);
		logic s;
		for (int n = 0; n <= limit; n++) begin
			s = (w == 0) ? sweepPhaseFlag : (w == 1) ? lowLimit : highLimitN;
			if (s === v) begin
				return;
			end
			@(negedge clk);
		end
		nMismatch++;
		$display("mismatch at %0t: wait %0d expected %h observed %h", $time, w, v, s);
	endtask

	// Line and external sources pulse a pin; single and remote write a latch bit
	task automatic fire(input int src);
		@(posedge clk);
		lineTrigN <= (src != 0);
		extTrigN <= (src != 1);
		if (src > 1) begin
			wr(ADDR_CTRL1, (src == 2) ? 8'h0B : 8'h07);
		end
		repeat (3) @(posedge clk);
		lineTrigN <= 1'b1;
		extTrigN <= 1'b1;
		wr(ADDR_CTRL1, 8'h0F);
		wrEnd;
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		forever begin
			@(sampleEv);
			compareVec(expQ.pop_front(), obsVec);
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		conclude;
	end

	initial begin
		void'($urandom(32'hC6FE4E21));
		shadow = '{RST_CTRL0, RST_CTRL1, RST_CTRL2, RST_RATE_HI};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		expectNow(1'b0);
		$display("reset values done");
		for (int i = 0; i < 30; i++) begin
			wr(ADDR_CTRL0, 8'($urandom) | 8'h01);
			// Odd passes hold by forward stop alone, so retrace stays live
			wr(ADDR_CTRL1, (8'($urandom) & (i[0] ? 8'hF0 : 8'hF2)) | (i[0] ? 8'h0D : 8'h0C));
			wr(ADDR_CTRL2, 8'($urandom));
			wr(ADDR_RATE_HI, 8'($urandom));
			wr(i[0] ? 16'h2013 : 16'h2018, 8'($urandom));
			wrEnd;
			expectNow(1'b0);
		end
		$display("random latch writes done");
		wr(ADDR_CTRL2, 8'h10);
		wr(ADDR_CTRL0, 8'h87);
		wr(ADDR_CTRL1, 8'h0F);
		wrEnd;
		for (int k = 0; k < 3; k++) begin
			waitSig(0, !k[0], 400);
			expectNow(!k[0]);
		end
		$display("internal free run done");
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_CTRL0, 8'h87 | {3'h0, trigCodes[m], 3'h0});
			wrEnd;
			waitSig(1, 1'b1, 300);
			repeat (8) @(negedge clk);
			fire(m);
			waitSig(0, 1'b0, 40);
			expectNow(1'b0);
			waitSig(2, 1'b0, 400);
			fire(m);
			waitSig(1, 1'b1, 300);
			repeat (8) @(negedge clk);
			expectNow(1'b1);
			$display("trigger source %0d done", m);
		end
		wr(ADDR_CTRL0, 8'h97);
		wrEnd;
		fire(1);
		waitSig(0, 1'b0, 40);
		wr(ADDR_CTRL0, 8'h96);
		wrEnd;
		waitSig(0, 1'b1, 8);
		expectNow(1'b1);
		$display("abort done");
		@(negedge clk);
		conclude;
	end
endmodule

bind srtc_core srtc_core_checker #(.MODE_INT(MODE_INT)) srtc_core_checker_i (.clk(clk),
	.rst_n(rst_n), .hostWrEn(hostWrEn), .hostAddr(hostAddr), .hostWrData(hostWrData),
	.highLimitN(highLimitN), .lowLimit(lowLimit), .rateCode(rateCode),
	.refBoostOn(refBoostOn), .capLargeSel(capLargeSel), .capSmallSel(capSmallSel),
	.manualFeedbackSel(manualFeedbackSel), .retraceEnable(retraceEnable),
	.stopHold(stopHold), .sweepPhaseFlag(sweepPhaseFlag), .clampRefRaise(clampRefRaise),
	.sweepOutPanel(sweepOutPanel), .trigMode(trigMode));
`default_nettype wire
